// ===== include/cam_pkg.sv
// Package for the acceptance mask stage: register map, fields, structs
package cam_pkg;
   localparam logic [3:0] CAM_ADDR_MASK_STD = 4'h0;
   localparam logic [3:0] CAM_ADDR_MASK_EIDH = 4'h1;
   localparam logic [3:0] CAM_ADDR_MASK_EIDL = 4'h2;
   localparam logic [3:0] CAM_ADDR_BIT_TIMING = 4'h3;
   localparam logic [3:0] CAM_ADDR_FILT_STD = 4'h4;
   localparam logic [3:0] CAM_ADDR_FILT_EIDH = 4'h5;
   localparam logic [3:0] CAM_ADDR_FILT_EIDL = 4'h6;
   localparam logic [3:0] CAM_ADDR_STATUS = 4'h7;
   localparam logic [15:0] CAM_STD_RMASK = 16'h1ffd;
   localparam logic [15:0] CAM_EIDH_RMASK = 16'h0fff;
   localparam logic [15:0] CAM_EIDL_RMASK = 16'hfc00;
   localparam logic [15:0] CAM_BT_RMASK = 16'h00ff;
   localparam logic [15:0] CAM_BT_RESET = 16'h0000;
   localparam int CAM_STD_LSB = 2;
   localparam int CAM_TYPE_BIT = 0;
   localparam int CAM_EIDL_LSB = 10;
   localparam int CAM_JUMP_LSB = 6;
   localparam int CAM_PRESCALE_LSB = 0;

   // Received identifier as delivered by the receive path
   typedef struct packed {
      logic valid;
      logic extended;
      logic [10:0] standard_identifier;
      logic [17:0] extended_identifier;
   } cam_rx_id_type;

   // Mask or filter contents in a flat form
   typedef struct packed {
      logic type_bit;
      logic [10:0] standard_identifier;
      logic [17:0] extended_identifier;
   } cam_idset_type;

   // Register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [15:0] wdata;
   } cam_req_type;
endpackage

// ===== rtl/cam_accept_mask.sv
// Acceptance mask stage top: registers, register port, match result
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module cam_accept_mask
   import cam_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [3:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   input wire cam_rx_id_type i_rx_id,
   output logic o_accept_valid,
   output logic o_accept,
   output logic [1:0] o_sync_jump_width,
   output logic [5:0] o_bit_rate_prescaler
);
   cam_req_type req;
   logic [15:0] msid_q, msid_d, meidh_q, meidh_d, meidl_q, meidl_d;
   logic [15:0] fsid_q, fsid_d, feidh_q, feidh_d, feidl_q, feidl_d;
   logic [15:0] bt_q, bt_d, rdata_q, rdata_d;
   logic acc_v_q, acc_v_d, acc_q, acc_d, hit_q, hit_d;
   cam_idset_type mask_set, filt_set;
   logic match;

   // Register only the written bits that exist
   function automatic logic [15:0] wr_field(input logic [15:0] old, input logic [15:0] wd,
                                             input logic [15:0] rm, input logic sel);
      wr_field = sel ? (wd & rm) : old;
   endfunction

   // Flatten three registers into an identifier set
   function automatic cam_idset_type to_set(input logic [15:0] s, input logic [15:0] h,
                                             input logic [15:0] l);
      cam_idset_type r;
      r.type_bit = s[CAM_TYPE_BIT];
      r.standard_identifier = s[CAM_STD_LSB +: 11];
      r.extended_identifier = {h[11:0], l[CAM_EIDL_LSB +: 6]};
      to_set = r;
   endfunction

   assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};
   assign mask_set = to_set(msid_q, meidh_q, meidl_q);
   assign filt_set = to_set(fsid_q, feidh_q, feidl_q);

   cam_compare cam_compare_i (
      .i_mask(mask_set),
      .i_filter(filt_set),
      .i_rx(i_rx_id),
      .o_match(match)
   );

   // Register writes and read mux; unimplemented bits stored as zero, and also masked to zero on read only for the mask registers
   always_comb
   begin
      msid_d = wr_field(msid_q, req.wdata, CAM_STD_RMASK, req.wr && req.addr == CAM_ADDR_MASK_STD);
      meidh_d = wr_field(meidh_q, req.wdata, CAM_EIDH_RMASK, req.wr && req.addr == CAM_ADDR_MASK_EIDH);
      meidl_d = wr_field(meidl_q, req.wdata, CAM_EIDL_RMASK, req.wr && req.addr == CAM_ADDR_MASK_EIDL);
      bt_d = wr_field(bt_q, req.wdata, CAM_BT_RMASK, req.wr && req.addr == CAM_ADDR_BIT_TIMING);
      fsid_d = wr_field(fsid_q, req.wdata, CAM_STD_RMASK, req.wr && req.addr == CAM_ADDR_FILT_STD);
      feidh_d = wr_field(feidh_q, req.wdata, CAM_EIDH_RMASK, req.wr && req.addr == CAM_ADDR_FILT_EIDH);
      feidl_d = wr_field(feidl_q, req.wdata, CAM_EIDL_RMASK, req.wr && req.addr == CAM_ADDR_FILT_EIDL);
      rdata_d = 16'h0000;
      if (req.rd)
      begin
         case (req.addr)
            CAM_ADDR_MASK_STD: rdata_d = msid_q & CAM_STD_RMASK;
            CAM_ADDR_MASK_EIDH: rdata_d = meidh_q & CAM_EIDH_RMASK;
            CAM_ADDR_MASK_EIDL: rdata_d = meidl_q & CAM_EIDL_RMASK;
            CAM_ADDR_BIT_TIMING: rdata_d = bt_q;
            CAM_ADDR_FILT_STD: rdata_d = fsid_q;
            CAM_ADDR_FILT_EIDH: rdata_d = feidh_q;
            CAM_ADDR_FILT_EIDL: rdata_d = feidl_q;
            CAM_ADDR_STATUS: rdata_d = {14'h0000, hit_q, acc_q};
            default: rdata_d = 16'h0000;
         endcase
      end
   end

   // Result of each received identifier, and sticky hit cleared by status read
   always_comb
   begin
      acc_v_d = i_rx_id.valid;
      acc_d = i_rx_id.valid ? match : acc_q;
      hit_d = hit_q;
      if (req.rd && req.addr == CAM_ADDR_STATUS)
      begin
         hit_d = 1'b0;
      end
      if (i_rx_id.valid && match)
      begin
         hit_d = 1'b1; // Set wins over clear
      end
   end

   // Masks and filters power up unknown; only control state resets
   always_ff @(posedge i_clock)
   begin
      msid_q <= msid_d;
      meidh_q <= meidh_d;
      meidl_q <= meidl_d;
      fsid_q <= fsid_d;
      feidh_q <= feidh_d;
      feidl_q <= feidl_d;
      if (i_rst)
      begin
         bt_q <= CAM_BT_RESET;
         rdata_q <= 16'h0000;
         acc_v_q <= 1'b0;
         acc_q <= 1'b0;
         hit_q <= 1'b0;
      end
      else
      begin
         bt_q <= bt_d;
         rdata_q <= rdata_d;
         acc_v_q <= acc_v_d;
         acc_q <= acc_d;
         hit_q <= hit_d;
      end
   end

   assign o_rdata = rdata_q;
   assign o_accept_valid = acc_v_q;
   assign o_accept = acc_q;
   assign o_sync_jump_width = bt_q[CAM_JUMP_LSB +: 2];
   assign o_bit_rate_prescaler = bt_q[CAM_PRESCALE_LSB +: 6];

   property p_std_unimpl;
      @(posedge i_clock) disable iff (i_rst)
         $past(req.rd) && $past(req.addr) == CAM_ADDR_MASK_STD |-> (o_rdata & ~CAM_STD_RMASK) == 16'h0000;
   endproperty
   a_std_unimpl: assert property (p_std_unimpl) else $error("standard mask unimplemented bits nonzero");
   property p_eidh_unimpl;
      @(posedge i_clock) disable iff (i_rst)
         $past(req.rd) && $past(req.addr) == CAM_ADDR_MASK_EIDH |-> o_rdata[15:12] == 4'h0;
   endproperty
   a_eidh_unimpl: assert property (p_eidh_unimpl) else $error("mask eidh upper bits nonzero");
   property p_eidl_unimpl;
      @(posedge i_clock) disable iff (i_rst)
         $past(req.rd) && $past(req.addr) == CAM_ADDR_MASK_EIDL |-> o_rdata[9:0] == 10'h000;
   endproperty
   a_eidl_unimpl: assert property (p_eidl_unimpl) else $error("mask eidl low bits nonzero");
   property p_type_strict;
      @(posedge i_clock) disable iff (i_rst)
         i_rx_id.valid && mask_set.type_bit && (i_rx_id.extended != filt_set.type_bit) |=> !o_accept;
   endproperty
   a_type_strict: assert property (p_type_strict) else $error("wrong frame type accepted");
   property p_zero_mask;
      @(posedge i_clock) disable iff (i_rst)
         i_rx_id.valid && !mask_set.type_bit && mask_set.standard_identifier == 11'h000
         && mask_set.extended_identifier == 18'h0_0000 |=> o_accept;
   endproperty
   a_zero_mask: assert property (p_zero_mask) else $error("all-excluded mask rejected");
   property p_std_mismatch;
      @(posedge i_clock) disable iff (i_rst)
         i_rx_id.valid && ((i_rx_id.standard_identifier ^ filt_set.standard_identifier)
         & mask_set.standard_identifier) != 11'h000 |=> !o_accept;
   endproperty
   a_std_mismatch: assert property (p_std_mismatch) else $error("included standard bit mismatch accepted");
   property p_ext_mismatch;
      @(posedge i_clock) disable iff (i_rst)
         i_rx_id.valid && i_rx_id.extended && ((i_rx_id.extended_identifier ^ filt_set.extended_identifier)
         & mask_set.extended_identifier) != 18'h0_0000 |=> !o_accept;
   endproperty
   a_ext_mismatch: assert property (p_ext_mismatch) else $error("included extended bit mismatch accepted");
   property p_exact;
      @(posedge i_clock) disable iff (i_rst)
         i_rx_id.valid && !mask_set.type_bit && {i_rx_id.standard_identifier, i_rx_id.extended_identifier}
         == {filt_set.standard_identifier, filt_set.extended_identifier} |=> o_accept && hit_q;
   endproperty
   a_exact: assert property (p_exact) else $error("exact identifier rejected");
   c_accept: cover property (@(posedge i_clock) disable iff (i_rst) o_accept_valid && o_accept);
   c_reject: cover property (@(posedge i_clock) disable iff (i_rst) o_accept_valid && !o_accept);
   c_ext: cover property (@(posedge i_clock) disable iff (i_rst) i_rx_id.valid && i_rx_id.extended && match);
endmodule
`default_nettype wire

// ===== rtl/cam_compare.sv
// Combinational masked identifier comparison
`timescale 1ns/1ns
`default_nettype none
module cam_compare
   import cam_pkg::*;
(
   input wire cam_idset_type i_mask,
   input wire cam_idset_type i_filter,
   input wire cam_rx_id_type i_rx,
   output logic o_match
);
   logic [28:0] rx_full;
   logic [28:0] flt_full;
   logic [28:0] msk_full;
   logic [28:0] diff;
   logic type_ok;
   // Standard bits form extended bits 28..18
   always_comb
   begin
      rx_full = {i_rx.standard_identifier, i_rx.extended_identifier};
      flt_full = {i_filter.standard_identifier, i_filter.extended_identifier};
      msk_full = {i_mask.standard_identifier, i_mask.extended_identifier};
      // Extended bits only count for extended filtering
      if (!(i_mask.type_bit ? i_filter.type_bit : i_rx.extended))
      begin
         msk_full[17:0] = 18'h0_0000;
      end
      diff = (rx_full ^ flt_full) & msk_full;
      type_ok = !i_mask.type_bit || (i_rx.extended == i_filter.type_bit);
      o_match = type_ok && (diff == 29'h0000_0000);
   end
endmodule
`default_nettype wire

// ===== tb/cam_accept_mask_tb.sv
// Self-checking testbench for the acceptance mask stage
`timescale 1ns/1ns
`default_nettype none
module cam_accept_mask_tb
   import cam_pkg::*;
;
   logic i_clock = 0, i_rst = 1, i_wr = 0, i_rd = 0;
   logic [3:0] i_addr = '0;
   logic [15:0] i_wdata = '0, o_rdata;
   logic o_accept_valid, o_accept;
   logic [1:0] o_sync_jump_width;
   logic [5:0] o_bit_rate_prescaler;
   cam_rx_id_type rx_id;
   int miscompares = 0, total_checks = 0, cycles = 0;
   cam_rx_source cam_rx_source_i (.i_clock(i_clock), .o_rx_id(rx_id));
   cam_accept_mask cam_accept_mask_i (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_id(rx_id), .o_accept_valid(o_accept_valid),
      .o_accept(o_accept), .o_sync_jump_width(o_sync_jump_width), .o_bit_rate_prescaler(o_bit_rate_prescaler));
   // Clock and hang guard
   always #2 i_clock = ~i_clock;
   always @(posedge i_clock)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         miscompares++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check_reg(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp);
      check_reg({15'h0, got}, {15'h0, exp});
   endtask
   // Register port cycles, entered just after an edge
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr <= 1'b0;
      @(posedge i_clock);
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 check_reg(o_rdata, exp);
      @(posedge i_clock);
   endtask
   // Program mask and filter in register layout
   task automatic setf(input logic [10:0] ms, input logic [17:0] me, input logic md, input logic [10:0] fs,
      input logic [17:0] fe, input logic fx);
      wr(CAM_ADDR_MASK_STD, {3'h0, ms, 1'b0, md});
      wr(CAM_ADDR_MASK_EIDH, {4'h0, me[17:6]});
      wr(CAM_ADDR_MASK_EIDL, {me[5:0], 10'h000});
      wr(CAM_ADDR_FILT_STD, {3'h0, fs, 1'b0, fx});
      wr(CAM_ADDR_FILT_EIDH, {4'h0, fe[17:6]});
      wr(CAM_ADDR_FILT_EIDL, {fe[5:0], 10'h000});
   endtask
   // Send one identifier and judge the result a cycle later
   task automatic rx(input logic ext, input logic [10:0] std_id, input logic [17:0] ext_id, input logic exp);
      cam_rx_source_i.send(ext, std_id, ext_id);
      #1 check_bit(o_accept_valid, 1'b1);
      check_bit(o_accept, exp);
      @(posedge i_clock);
   endtask
   task automatic test_regs();
      rd(CAM_ADDR_BIT_TIMING, 16'h0000);
      rd(CAM_ADDR_STATUS, 16'h0000);
      wr(CAM_ADDR_MASK_STD, 16'hffff);
      wr(CAM_ADDR_MASK_EIDH, 16'hffff);
      wr(CAM_ADDR_MASK_EIDL, 16'hffff);
      wr(CAM_ADDR_FILT_STD, 16'hffff);
      wr(CAM_ADDR_FILT_EIDH, 16'hffff);
      wr(CAM_ADDR_FILT_EIDL, 16'hffff);
      wr(CAM_ADDR_BIT_TIMING, 16'hffff);
      wr(4'h8, 16'hffff);
      rd(CAM_ADDR_MASK_STD, 16'h1ffd);
      rd(CAM_ADDR_MASK_EIDH, 16'h0fff);
      rd(CAM_ADDR_MASK_EIDL, 16'hfc00);
      rd(CAM_ADDR_FILT_STD, 16'h1ffd);
      rd(CAM_ADDR_FILT_EIDH, 16'h0fff);
      rd(CAM_ADDR_FILT_EIDL, 16'hfc00);
      rd(CAM_ADDR_BIT_TIMING, 16'h00ff);
      rd(4'h8, 16'h0000);
      check_reg({8'h00, o_sync_jump_width, o_bit_rate_prescaler}, 16'h00ff);
      $display("test regs done");
   endtask
   task automatic test_std();
      setf(11'h7ff, 18'h0_0000, 1'b0, 11'h123, 18'h0_0000, 1'b0);
      rx(1'b0, 11'h123, 18'h3_ffff, 1'b1);
      rx(1'b0, 11'h122, 18'h0_0000, 1'b0);
      setf(11'h7fe, 18'h0_0000, 1'b0, 11'h123, 18'h0_0000, 1'b0);
      rx(1'b0, 11'h122, 18'h0_0000, 1'b1);
      setf(11'h000, 18'h0_0000, 1'b0, 11'h123, 18'h0_0000, 1'b0);
      rx(1'b1, 11'h456, 18'h1_2345, 1'b1);
      $display("test std done");
   endtask
   task automatic test_ext();
      setf(11'h7ff, 18'h3_ffff, 1'b0, 11'h0a5, 18'h2_a5c3, 1'b0);
      rx(1'b1, 11'h0a5, 18'h2_a5c3, 1'b1);
      rx(1'b1, 11'h0a5, 18'h2_a583, 1'b0);
      rx(1'b1, 11'h0a5, 18'h2_a5c2, 1'b0);
      rx(1'b1, 11'h0a4, 18'h2_a5c3, 1'b0);
      rx(1'b0, 11'h0a5, 18'h0_0000, 1'b1);
      setf(11'h7ff, 18'h3_ffbe, 1'b0, 11'h0a5, 18'h2_a5c3, 1'b0);
      rx(1'b1, 11'h0a5, 18'h2_a582, 1'b1);
      $display("test ext done");
   endtask
   // Sticky hit, its clear on status read, and set winning over clear
   task automatic test_status();
      setf(11'h7ff, 18'h3_ffff, 1'b0, 11'h0a5, 18'h2_a5c3, 1'b0);
      rx(1'b1, 11'h0a5, 18'h2_a5c3, 1'b1);
      rd(CAM_ADDR_STATUS, 16'h0003);
      rd(CAM_ADDR_STATUS, 16'h0001);
      rx(1'b1, 11'h0a4, 18'h2_a5c3, 1'b0);
      rd(CAM_ADDR_STATUS, 16'h0000);
      fork
         rx(1'b0, 11'h0a5, 18'h0_0000, 1'b1);
         rd(CAM_ADDR_STATUS, 16'h0000);
      join
      rd(CAM_ADDR_STATUS, 16'h0003);
      $display("test status done");
   endtask
   task automatic test_type();
      setf(11'h7ff, 18'h3_ffff, 1'b1, 11'h0a5, 18'h2_a5c3, 1'b1);
      rx(1'b0, 11'h0a5, 18'h2_a5c3, 1'b0);
      rx(1'b1, 11'h0a5, 18'h2_a5c3, 1'b1);
      setf(11'h7ff, 18'h3_ffff, 1'b1, 11'h0a5, 18'h2_a5c3, 1'b0);
      rx(1'b1, 11'h0a5, 18'h2_a5c3, 1'b0);
      rx(1'b0, 11'h0a5, 18'h2_a5c3, 1'b1);
      rx(1'b0, 11'h0a5, 18'h0_0000, 1'b1);
      $display("test type done");
   endtask
   // Mid-run reset: control state clears, masks keep their contents
   task automatic test_reset();
      wr(CAM_ADDR_BIT_TIMING, 16'h00c5);
      check_reg({8'h00, o_sync_jump_width, o_bit_rate_prescaler}, 16'h00c5);
      i_rst <= 1'b1;
      repeat (3) @(posedge i_clock);
      i_rst <= 1'b0;
      #1 check_reg({8'h00, o_sync_jump_width, o_bit_rate_prescaler}, 16'h0000);
      check_bit(o_accept, 1'b0);
      check_bit(o_accept_valid, 1'b0);
      @(posedge i_clock);
      rd(CAM_ADDR_BIT_TIMING, 16'h0000);
      rd(CAM_ADDR_STATUS, 16'h0000);
      rd(CAM_ADDR_MASK_STD, 16'h1ffd);
      $display("test reset done");
   endtask
   // Main sequence
   initial
   begin
      repeat (6) @(posedge i_clock);
      i_rst <= 1'b0;
      @(posedge i_clock);
      test_regs();
      test_std();
      test_ext();
      test_status();
      test_type();
      test_reset();
      give_verdict();
   end
endmodule
`default_nettype wire

// ===== tb/cam_rx_source.sv
// Model of remote nodes delivering received identifiers
`timescale 1ns/1ns
`default_nettype none
module cam_rx_source
   import cam_pkg::*;
(
   input wire logic i_clock,
   output var cam_rx_id_type o_rx_id
);
   initial o_rx_id = '0;
   // One-cycle identifier, then valid low with inverted payload
   task automatic send(input logic ext, input logic [10:0] std_id, input logic [17:0] ext_id);
      o_rx_id <= {1'b1, ext, std_id, ext_id};
      @(posedge i_clock);
      o_rx_id <= {1'b0, ~ext, ~std_id, ~ext_id};
   endtask
endmodule
`default_nettype wire
